/* File: logic/wrf_pkg.sv */
// package for the cpu working register file: sizes, pointer indices and encodings
package wrf_pkg;
  localparam int unsigned NUM_REGS   = 32;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned PTR_W      = 16;
  localparam int unsigned DISP_W     = 6;
  localparam logic [4:0]  IMM_BASE   = 5'h10;
  localparam logic [4:0]  PTR_A_LOW  = 5'h1A;
  localparam logic [4:0]  PTR_A_HIGH = 5'h1B;
  localparam logic [4:0]  PTR_B_LOW  = 5'h1C;
  localparam logic [4:0]  PTR_B_HIGH = 5'h1D;
  localparam logic [4:0]  PTR_C_LOW  = 5'h1E;
  localparam logic [4:0]  PTR_C_HIGH = 5'h1F;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [15:0] PTR_STEP   = 16'h0001;

  // pointer selection
  typedef enum logic [1:0] {
    WRF_PTR_A,
    WRF_PTR_B,
    WRF_PTR_C,
    WRF_PTR_NONE
  } wrf_ptr_sel_t;

  // pointer addressing modes
  typedef enum logic [1:0] {
    WRF_AM_DISP,
    WRF_AM_POSTINC,
    WRF_AM_PREDEC
  } wrf_addr_mode_t;
endpackage

/* File: logic/wrf_regfile.sv */
// cpu working register file: 32 x 8-bit registers with three 16-bit pointers
`timescale 1ns/1ps

module wrf_regfile #(
  parameter int unsigned NUM_REGS = wrf_pkg::NUM_REGS,
  parameter int unsigned DATA_W   = wrf_pkg::DATA_W
) (
  input  wire logic                         core_clk,      // cpu clock
  input  wire logic                         rstn,          // async reset, active low
  input  wire logic [wrf_pkg::IDX_W-1:0]    rd_a_idx,      // operand a index
  output logic      [DATA_W-1:0]            rd_a_data,     // operand a value
  input  wire logic [wrf_pkg::IDX_W-1:0]    rd_b_idx,      // operand b index
  output logic      [DATA_W-1:0]            rd_b_data,     // operand b value
  input  wire logic                         wr_en,         // result write strobe
  input  wire logic [wrf_pkg::IDX_W-1:0]    wr_idx,        // result destination
  input  wire logic [DATA_W-1:0]            wr_data,       // result value
  input  wire logic                         imm_instr,     // immediate-operand instruction
  input  wire logic [3:0]                   imm_idx,       // upper-half register number
  input  wire logic                         wr_pair_en,    // 16-bit pair write strobe
  input  wire logic [wrf_pkg::IDX_W-1:0]    wr_pair_idx,   // even index of pair
  input  wire logic [2*DATA_W-1:0]          wr_pair_data,  // pair value
  input  wire wrf_pkg::wrf_ptr_sel_t        ptr_sel,       // pointer in use
  input  wire wrf_pkg::wrf_addr_mode_t      ptr_mode,      // pointer addressing mode
  input  wire logic [wrf_pkg::DISP_W-1:0]   ptr_disp,      // fixed displacement
  input  wire logic                         ptr_go,        // pointer access strobe
  output logic      [wrf_pkg::PTR_W-1:0]    ptr_addr,      // effective address
  output logic      [wrf_pkg::PTR_W-1:0]    ptr_a_val,     // first pointer
  output logic      [wrf_pkg::PTR_W-1:0]    ptr_b_val,     // second pointer
  output logic      [wrf_pkg::PTR_W-1:0]    ptr_c_val,     // third pointer
  output logic      [wrf_pkg::PTR_W-1:0]    prog_addr,     // program memory pointer
  output logic                              imm_wr_err,    // immediate write named lower half
  input  wire logic                         core_halted,   // core in stopped state
  input  wire logic                         dbg_en,        // debug access strobe
  input  wire logic                         dbg_we,        // debug write
  input  wire logic [wrf_pkg::IDX_W-1:0]    dbg_idx,       // debug index
  input  wire logic [DATA_W-1:0]            dbg_wdata,     // debug write data
  output logic      [DATA_W-1:0]            dbg_rdata      // debug read data
);

  // ------------------------------------------------------------
  // storage and pointer views
  // ------------------------------------------------------------
  logic [DATA_W-1:0] regs_reg [NUM_REGS];
  logic [DATA_W-1:0] regs_next [NUM_REGS];
  logic [DATA_W-1:0] dbg_rdata_reg;
  logic [DATA_W-1:0] dbg_rdata_next;
  logic              imm_wr_err_reg;
  logic              imm_misroute;
  logic [wrf_pkg::PTR_W-1:0] ptr_cur;
  logic [wrf_pkg::PTR_W-1:0] ptr_next;
  logic [wrf_pkg::IDX_W-1:0] ptr_low_idx;
  logic [wrf_pkg::IDX_W-1:0] ptr_high_idx;
  logic [wrf_pkg::IDX_W-1:0] eff_wr_idx;
  logic                      eff_wr_en;
  logic                      dbg_ok;
  logic                      ptr_upd;

  // pairs start on an even index; the partner is the same index with bit 0 set
  function automatic logic [wrf_pkg::IDX_W-1:0] pair_lo(input logic [wrf_pkg::IDX_W-1:0] idx);
    pair_lo = {idx[wrf_pkg::IDX_W-1:1], 1'b0};
  endfunction

  function automatic logic [wrf_pkg::IDX_W-1:0] pair_hi(input logic [wrf_pkg::IDX_W-1:0] idx);
    pair_hi = {idx[wrf_pkg::IDX_W-1:1], 1'b1};
  endfunction

  function automatic logic [wrf_pkg::PTR_W-1:0] pair_val(input logic [wrf_pkg::IDX_W-1:0] lo);
    pair_val = {regs_reg[pair_hi(lo)], regs_reg[pair_lo(lo)]};
  endfunction

  assign ptr_a_val = pair_val(wrf_pkg::PTR_A_LOW);
  assign ptr_b_val = pair_val(wrf_pkg::PTR_B_LOW);
  assign ptr_c_val = pair_val(wrf_pkg::PTR_C_LOW);
  assign prog_addr = ptr_c_val;

  // ------------------------------------------------------------
  // read ports
  // ------------------------------------------------------------
  // combinational reads: same-cycle access, index n is address n
  // a write shows on the read ports only after its edge, never bypassed
  assign rd_a_data = regs_reg[rd_a_idx];
  assign rd_b_data = regs_reg[rd_b_idx];

  // ------------------------------------------------------------
  // immediate destination
  // ------------------------------------------------------------
  // immediate instructions can only name 16..31
  always_comb begin
    eff_wr_idx = wr_idx;
    if (imm_instr) begin
      eff_wr_idx = wrf_pkg::IMM_BASE | {1'b0, imm_idx};
    end
  end
  assign eff_wr_en = wr_en;

  // ------------------------------------------------------------
  // pointer addressing
  // ------------------------------------------------------------
  always_comb begin
    unique case (ptr_sel)
      wrf_pkg::WRF_PTR_A: ptr_low_idx = wrf_pkg::PTR_A_LOW;
      wrf_pkg::WRF_PTR_B: ptr_low_idx = wrf_pkg::PTR_B_LOW;
      default:            ptr_low_idx = wrf_pkg::PTR_C_LOW;
    endcase
    ptr_cur  = pair_val(ptr_low_idx);
    ptr_next = ptr_cur;
    ptr_addr = ptr_cur;
    unique case (ptr_mode)
      wrf_pkg::WRF_AM_POSTINC: begin
        // wraps at 16 bits; the pointer has no carry out
        ptr_next = ptr_cur + wrf_pkg::PTR_STEP;
      end
      wrf_pkg::WRF_AM_PREDEC: begin
        ptr_next = ptr_cur - wrf_pkg::PTR_STEP;
        ptr_addr = ptr_next;
      end
      default: begin
        ptr_addr = ptr_cur + {{(wrf_pkg::PTR_W-wrf_pkg::DISP_W){1'b0}}, ptr_disp};
      end
    endcase
  end
  assign ptr_upd = ptr_go && (ptr_sel != wrf_pkg::WRF_PTR_NONE)
                   && (ptr_mode != wrf_pkg::WRF_AM_DISP);
  assign ptr_high_idx = pair_hi(ptr_low_idx);

  // debug only acts while halted; a core write on the same edge still loses to it
  assign dbg_ok = dbg_en && core_halted;

  // ------------------------------------------------------------
  // per-register write select
  // ------------------------------------------------------------
  // each register picks its own next value; later sources override earlier
  // ones, so on one edge: pointer update < pair write < byte write < debug write
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    localparam logic [wrf_pkg::IDX_W-1:0] IDX = (wrf_pkg::IDX_W)'(g);
    logic hit_ptr_lo;
    logic hit_ptr_hi;
    logic hit_pair_lo;
    logic hit_pair_hi;
    logic hit_byte;
    logic hit_dbg;

    assign hit_ptr_lo  = ptr_upd && (ptr_low_idx == IDX);
    assign hit_ptr_hi  = ptr_upd && (ptr_high_idx == IDX);
    assign hit_pair_lo = wr_pair_en && (pair_lo(wr_pair_idx) == IDX);
    assign hit_pair_hi = wr_pair_en && (pair_hi(wr_pair_idx) == IDX);
    assign hit_byte    = eff_wr_en && (eff_wr_idx == IDX);
    assign hit_dbg     = dbg_ok && dbg_we && (dbg_idx == IDX);

    always_comb begin
      regs_next[g] = regs_reg[g];
      if (hit_ptr_lo) begin
        regs_next[g] = ptr_next[DATA_W-1:0];
      end
      if (hit_ptr_hi) begin
        regs_next[g] = ptr_next[2*DATA_W-1:DATA_W];
      end
      if (hit_pair_lo) begin
        regs_next[g] = wr_pair_data[DATA_W-1:0];
      end
      if (hit_pair_hi) begin
        regs_next[g] = wr_pair_data[2*DATA_W-1:DATA_W];
      end
      if (hit_byte) begin
        regs_next[g] = wr_data;
      end
      if (hit_dbg) begin
        regs_next[g] = dbg_wdata;
      end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        regs_reg[g] <= wrf_pkg::REG_RESET;
      end else begin
        regs_reg[g] <= regs_next[g];
      end
    end
  end

  // ------------------------------------------------------------
  // debug read data and diagnostics
  // ------------------------------------------------------------
  // debug read samples the value before any same-edge write lands
  always_comb begin
    dbg_rdata_next = dbg_rdata_reg;
    if (dbg_ok) begin
      dbg_rdata_next = regs_reg[dbg_idx];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dbg_rdata_reg <= wrf_pkg::REG_RESET;
    end else begin
      dbg_rdata_reg <= dbg_rdata_next;
    end
  end
  assign dbg_rdata = dbg_rdata_reg;

  // flags a decoder driving wr_idx below 16 with imm_instr (index was forced high)
  assign imm_misroute = wr_en && imm_instr && (wr_idx < wrf_pkg::IMM_BASE);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      imm_wr_err_reg <= 1'b0;
    end else begin
      imm_wr_err_reg <= imm_misroute;
    end
  end
  assign imm_wr_err = imm_wr_err_reg;

endmodule // wrf_regfile

/* File: testbench/wrf_cpu_model.sv */
// cpu datapath model: result write-back into the register file
`timescale 1ns/1ps
module wrf_cpu_model (
  input wire logic   core_clk,  // cpu clock
  output logic       wr_en,     // result write strobe
  output logic       imm_instr, // immediate form
  output logic [4:0] wr_idx,    // destination
  output logic [3:0] imm_idx,   // upper-half number only
  output logic [7:0] wr_data    // result
);
  initial {wr_en, imm_instr, wr_idx, imm_idx, wr_data} = '0;
  task automatic wr(logic [4:0] i, logic [7:0] d, logic im);
    @(negedge core_clk) {wr_en, imm_instr, wr_idx, imm_idx, wr_data} = {1'b1, im, i, i[3:0], d};
    @(negedge core_clk) wr_en = 1'b0;
  endtask
endmodule // wrf_cpu_model

/* File: testbench/wrf_regfile_assertions.sv */
// assertions on the working register file ports
`timescale 1ns/1ps
module wrf_regfile_assertions (
  input wire logic                    core_clk,     // cpu clock
  input wire logic                    rstn,         // async reset, active low
  input wire logic                    wr_en,        // result write strobe
  input wire logic                    imm_instr,    // immediate form
  input wire logic                    wr_pair_en,   // pair write strobe
  input wire logic                    ptr_go,       // pointer access strobe
  input wire logic                    dbg_en,       // debug access strobe
  input wire logic                    core_halted,  // core stopped
  input wire logic                    imm_wr_err,   // misrouted immediate flag
  input wire logic [4:0]              wr_idx,       // result destination
  input wire logic [4:0]              rd_a_idx,     // operand a index
  input wire logic [4:0]              dbg_idx,      // debug index
  input wire logic [7:0]              wr_data,      // result value
  input wire logic [7:0]              rd_a_data,    // operand a value
  input wire logic [7:0]              dbg_rdata,    // debug read data
  input wire wrf_pkg::wrf_ptr_sel_t   ptr_sel,      // pointer in use
  input wire wrf_pkg::wrf_addr_mode_t ptr_mode,     // addressing mode
  input wire logic [15:0]             ptr_addr,     // effective address
  input wire logic [15:0]             ptr_a_val,    // first pointer
  input wire logic [15:0]             ptr_b_val,    // second pointer
  input wire logic [15:0]             ptr_c_val,    // third pointer
  input wire logic [15:0]             prog_addr     // program memory pointer
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_wr; wr_en && !imm_instr && !(dbg_en && core_halted); endsequence
  // pointer step with no competing write on the same edge
  sequence s_go(s, m);
    ptr_go && ptr_sel == s && ptr_mode == m && !(wr_en || wr_pair_en || dbg_en);
  endsequence
  a_imm_set: assert property (wr_en && imm_instr && wr_idx < 5'h10 |=> imm_wr_err)
    else $error("flag missing");
  a_imm_clear: assert property (!(wr_en && imm_instr && wr_idx < 5'h10) |=> !imm_wr_err)
    else $error("flag spurious");
  a_byte_wr: assert property (s_wr ##1 rd_a_idx == $past(wr_idx)
    |-> rd_a_data == $past(wr_data)) else $error("write lost");
  a_dbg_read: assert property (dbg_en && core_halted && rd_a_idx == dbg_idx
    |=> dbg_rdata == $past(rd_a_data)) else $error("debug read");
  a_dbg_hold: assert property (!(dbg_en && core_halted) |=> $stable(dbg_rdata))
    else $error("debug data moved");
  a_post_inc: assert property (s_go(wrf_pkg::WRF_PTR_A, wrf_pkg::WRF_AM_POSTINC) |->
    ptr_addr == ptr_a_val ##1 ptr_a_val == $past(ptr_a_val) + 16'h0001) else $error("inc");
  a_pre_dec: assert property (s_go(wrf_pkg::WRF_PTR_B, wrf_pkg::WRF_AM_PREDEC) |->
    ptr_addr == ptr_b_val - 16'h0001 ##1 ptr_b_val == $past(ptr_b_val) - 16'h0001)
    else $error("dec");
  a_prog_ptr: assert property (prog_addr == ptr_c_val) else $error("program pointer");
  a_disp_hold: assert property (s_go(wrf_pkg::WRF_PTR_C, wrf_pkg::WRF_AM_DISP) |=>
    $stable(ptr_c_val)) else $error("displacement moved pointer");
endmodule // wrf_regfile_assertions

/* File: testbench/wrf_regfile_tb.sv */
// self-checking bench for the working register file
`timescale 1ns/1ps
module wrf_regfile_tb;
  logic core_clk = 1'b0, rstn = 1'b0, wr_pair_en = 1'b0, ptr_go = 1'b0, core_halted = 1'b0;
  logic dbg_en = 1'b0, dbg_we = 1'b0, wr_en, imm_instr, imm_wr_err;
  logic [4:0] rd_a_idx = '0, rd_b_idx = '0, wr_pair_idx = '0, dbg_idx = '0, wr_idx;
  logic [7:0] dbg_wdata = '0, wr_data, rd_a_data, rd_b_data, dbg_rdata;
  logic [15:0] wr_pair_data = '0, ptr_addr, ptr_a_val, ptr_b_val, ptr_c_val, prog_addr;
  logic [5:0] ptr_disp = '0;
  logic [3:0] imm_idx;
  wrf_pkg::wrf_ptr_sel_t ptr_sel = wrf_pkg::WRF_PTR_NONE;
  wrf_pkg::wrf_addr_mode_t ptr_mode = wrf_pkg::WRF_AM_DISP;
  int errors = 0, checks = 0;
  always #2 core_clk = ~core_clk;
  wrf_regfile wrf_regfile_i (.*);
  wrf_cpu_model wrf_cpu_model_i (.*);
  task automatic chk(string n, logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [4:0] i, logic [7:0] d, logic im); wrf_cpu_model_i.wr(i, d, im); endtask
  task automatic rdchk(logic [4:0] i, logic [7:0] e);
    @(negedge core_clk) rd_b_idx = i;
    #1 chk("reg", rd_b_data, e);
  endtask
  task automatic pair(logic [4:0] i, logic [15:0] d);
    @(negedge core_clk) {wr_pair_en, wr_pair_idx, wr_pair_data} = {1'b1, i, d};
    @(negedge core_clk) wr_pair_en = 1'b0;
  endtask
  task automatic go(wrf_pkg::wrf_ptr_sel_t s, wrf_pkg::wrf_addr_mode_t m, logic [5:0] d);
    @(negedge core_clk) ptr_go = 1'b1;
    ptr_sel = s;
    ptr_mode = m;
    ptr_disp = d;
    @(negedge core_clk) ptr_go = 1'b0;
  endtask
  // rd_a follows the debug index so the pre-write value can be compared
  task automatic dbg(logic h, w, logic [4:0] i, logic [7:0] d);
    @(negedge core_clk) {core_halted, dbg_we, dbg_idx, dbg_wdata, dbg_en} = {h, w, i, d, 1'b1};
    rd_a_idx = i;
    @(negedge core_clk) dbg_en = 1'b0;
  endtask
  task automatic t_regs();
    for (int i = 0; i < 32; i++) rdchk(5'(i), 8'h00);
    for (int i = 0; i < 32; i++) begin
      wr(5'(i), 8'hA5 ^ 8'(i), 1'b0);
      rd_a_idx = 5'(i);
    end
    for (int i = 0; i < 32; i++) rdchk(5'(i), 8'hA5 ^ 8'(i));
  endtask
  task automatic t_imm();
    wr(5'h1F, 8'h3C, 1'b1);
    chk("imm_err", imm_wr_err, 16'h0000);
    wr(5'h03, 8'hC3, 1'b1);
    chk("imm_err", imm_wr_err, 16'h0001);
    @(negedge core_clk) chk("imm_err", imm_wr_err, 16'h0000);
    rdchk(5'h1F, 8'h3C);
    rdchk(5'h13, 8'hC3);
    rdchk(5'h03, 8'hA6);
  endtask
  task automatic t_ptr();
    pair(5'h1A, 16'h12FF);
    chk("ptr_a", ptr_a_val, 16'h12FF);
    rdchk(5'h1B, 8'h12);
    go(wrf_pkg::WRF_PTR_A, wrf_pkg::WRF_AM_POSTINC, 6'h00);
    chk("ptr_a", ptr_a_val, 16'h1300);
    pair(5'h1C, 16'h0100);
    go(wrf_pkg::WRF_PTR_B, wrf_pkg::WRF_AM_PREDEC, 6'h00);
    wr(5'h1D, 8'h7E, 1'b0);
    chk("ptr_b", ptr_b_val, 16'h7EFF);
    pair(5'h1E, 16'h8000);
    go(wrf_pkg::WRF_PTR_C, wrf_pkg::WRF_AM_DISP, 6'h3F);
    chk("disp", ptr_addr, 16'h803F);
    chk("prog", prog_addr, 16'h8000);
    chk("ptr_c", ptr_c_val, 16'h8000);
    go(wrf_pkg::WRF_PTR_NONE, wrf_pkg::WRF_AM_POSTINC, 6'h00);
    chk("ptr_c", ptr_c_val, 16'h8000);
    chk("ptr_a", ptr_a_val, 16'h1300);
    go(wrf_pkg::WRF_PTR_C, wrf_pkg::WRF_AM_PREDEC, 6'h00);
    chk("ptr_c", ptr_c_val, 16'h7FFF);
    chk("prog", prog_addr, 16'h7FFF);
  endtask
  task automatic t_dbg();
    dbg(1'b0, 1'b1, 5'h05, 8'h11);
    rdchk(5'h05, 8'hA0);
    dbg(1'b1, 1'b1, 5'h05, 8'h11);
    chk("dbg", dbg_rdata, 16'h00A0);
    rdchk(5'h05, 8'h11);
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) rstn = 1'b1;
    t_regs();
    t_imm();
    t_ptr();
    t_dbg();
    end_sim();
  end
  initial begin
    #20000 errors++;
    end_sim();
  end
endmodule // wrf_regfile_tb
bind wrf_regfile wrf_regfile_assertions wrf_regfile_assertions_i (.*);
